// File: design/pbc_regs.sv
// Register bank: second synthesizer loop settings and nonvolatile program count.
// Assumes a host bus front end giving one-cycle read/write strobes with an 8-bit
// address, and a nonvolatile store that reports loads and completed programs.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Filter order code 3 selects second order; it is the reset value.
// R2 - Filter order code 7 selects third order; other codes reserved.
// R3 - Closed-loop wait codes 0..3 give 30us, 300us, 30ms, 300ms.
// R4 - Host uses closed-loop wait code 1 above 10 kHz bandwidth.
// R5 - Oscillator wait codes give 20us, 400us, 8ms, 200ms; resets to 1.
// R6 - Host keeps oscillator wait at code 1 always.
// R7 - Narrow-bandwidth bit one selects jitter-cleaner mode, about 200 Hz.
// R8 - Narrow-bandwidth bit zero, reset value, selects clock-generator mode.
// R9 - Host changing bandwidth bit also reprograms detector, pump, filter.
// R10 - Program count increments by one after each program completion reported while idle and not in the same cycle as a load trigger.
// R11 - Program count is kept in the nonvolatile store.
// R12 - Count reloads after reset, after a load, after each program.
// R13 - Count saturates at 255.
// R14 - Store loads registers after reset and on a self-clearing trigger.
// R15 - Reserved bits read zero; writes to them and the count ignored.
module pbc_regs import pbc_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic nonvolatile_load_trigger_i,
	output logic load_busy_o,
	input wire logic nv_load_done_i,
	input wire logic [2:0] nv_filter_order_i,
	input wire logic [1:0] nv_closed_loop_wait_i,
	input wire logic [1:0] nv_osc_settle_wait_i,
	input wire logic nv_narrow_bandwidth_i,
	input wire logic [7:0] nv_cycle_count_i,
	input wire logic nv_prog_done_i,
	output logic nv_count_we_o,
	output logic [7:0] nv_count_wdata_o,
	output logic [2:0] pll_b_filter_order_sel_o,
	output logic pll_b_third_order_o,
	output logic [23:0] pll_b_closed_loop_cycles_o,
	output logic [23:0] pll_b_osc_settle_cycles_o,
	output logic pll_b_jitter_cleaner_o
);
	// ***************************************************************
	// Load sequencing
	// ***************************************************************
	pbc_state_e state_r;
	logic [2:0] pll_b_filter_order_sel_r;
	logic [1:0] closed_loop_wait_code_r;
	logic [1:0] osc_settle_wait_code_r;
	logic pll_b_narrow_bandwidth_r;
	logic [7:0] nonvolatile_cycle_count_r;
	logic [7:0] count_nxt;
	logic host_wr;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= PBC_ST_LOAD; // [R14]
		end else begin
			unique case (state_r)
				PBC_ST_LOAD: begin
					if (nv_load_done_i) begin
						state_r <= PBC_ST_IDLE;
					end
				end
				PBC_ST_IDLE: begin
					if (nonvolatile_load_trigger_i) begin
						state_r <= PBC_ST_LOAD; // [R14]
					end else if (nv_prog_done_i) begin
						state_r <= PBC_ST_PROG;
					end
				end
				PBC_ST_PROG: begin
					state_r <= PBC_ST_LOAD; // [R12]
				end
				default: begin
					state_r <= PBC_ST_LOAD;
				end
			endcase
		end
	end

	assign load_busy_o = (state_r != PBC_ST_IDLE);
	assign host_wr = reg_wr_i && (state_r == PBC_ST_IDLE);

	// ***************************************************************
	// Settings registers
	// ***************************************************************
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pll_b_filter_order_sel_r <= PBC_FILTER_RST; // [R1]
			closed_loop_wait_code_r <= PBC_CLSD_RST;
			osc_settle_wait_code_r <= PBC_OSC_RST; // [R5]
			pll_b_narrow_bandwidth_r <= PBC_NARROW_RST; // [R8]
		end else if (state_r == PBC_ST_LOAD && nv_load_done_i) begin
			pll_b_filter_order_sel_r <= nv_filter_order_i;
			closed_loop_wait_code_r <= nv_closed_loop_wait_i;
			osc_settle_wait_code_r <= nv_osc_settle_wait_i;
			pll_b_narrow_bandwidth_r <= nv_narrow_bandwidth_i;
		end else if (host_wr) begin
			// Only the defined field bits are stored.
			if (reg_addr_i == PBC_OFF_FILTER_ORDER) begin
				pll_b_filter_order_sel_r <= reg_wdata_i[2:0]; // [R15]
			end
			if (reg_addr_i == PBC_OFF_SETTLE_WAITS) begin
				closed_loop_wait_code_r <= reg_wdata_i[PBC_CLSD_LSB +: 2];
				osc_settle_wait_code_r <= reg_wdata_i[PBC_OSC_LSB +: 2];
			end
			if (reg_addr_i == PBC_OFF_BW_SELECT) begin
				pll_b_narrow_bandwidth_r <= reg_wdata_i[0];
			end
		end
	end

	// ***************************************************************
	// Program count
	// ***************************************************************
	assign count_nxt = (nonvolatile_cycle_count_r == PBC_COUNT_MAX) ?
		nonvolatile_cycle_count_r : nonvolatile_cycle_count_r + 8'h01; // [R13]

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			nonvolatile_cycle_count_r <= PBC_COUNT_RST;
		end else if (state_r == PBC_ST_LOAD && nv_load_done_i) begin
			nonvolatile_cycle_count_r <= nv_cycle_count_i; // [R12]
		end else if (state_r == PBC_ST_IDLE && nv_prog_done_i && !nonvolatile_load_trigger_i) begin
			nonvolatile_cycle_count_r <= count_nxt; // [R10]
		end
	end

	// The incremented count is written back to the store for persistence.
	assign nv_count_we_o = (state_r == PBC_ST_PROG); // [R11]
	assign nv_count_wdata_o = nonvolatile_cycle_count_r;

	// ***************************************************************
	// Outputs to the synthesizer
	// ***************************************************************
	assign pll_b_filter_order_sel_o = pll_b_filter_order_sel_r;
	assign pll_b_third_order_o = (pll_b_filter_order_sel_r == PBC_FILTER_3RD); // [R2]
	assign pll_b_jitter_cleaner_o = pll_b_narrow_bandwidth_r; // [R7] [R8]

	always_comb begin
		unique case (closed_loop_wait_code_r)
			2'h0: pll_b_closed_loop_cycles_o = PBC_CLSD_CYC0; // [R3]
			2'h1: pll_b_closed_loop_cycles_o = PBC_CLSD_CYC1;
			2'h2: pll_b_closed_loop_cycles_o = PBC_CLSD_CYC2;
			2'h3: pll_b_closed_loop_cycles_o = PBC_CLSD_CYC3;
		endcase
		unique case (osc_settle_wait_code_r)
			2'h0: pll_b_osc_settle_cycles_o = PBC_OSC_CYC0; // [R5]
			2'h1: pll_b_osc_settle_cycles_o = PBC_OSC_CYC1;
			2'h2: pll_b_osc_settle_cycles_o = PBC_OSC_CYC2;
			2'h3: pll_b_osc_settle_cycles_o = PBC_OSC_CYC3;
		endcase
	end

	// ***************************************************************
	// Read data
	// ***************************************************************
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				PBC_OFF_FILTER_ORDER: reg_rdata_o <= {5'h00, pll_b_filter_order_sel_r}; // [R15]
				PBC_OFF_SETTLE_WAITS: reg_rdata_o <= {4'h0, closed_loop_wait_code_r,
					osc_settle_wait_code_r};
				PBC_OFF_BW_SELECT: reg_rdata_o <= {7'h00, pll_b_narrow_bandwidth_r};
				PBC_OFF_PROG_COUNT: reg_rdata_o <= nonvolatile_cycle_count_r;
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	a_filter_rst: assert property (@(posedge clk_i) $fell(sys_rst_i) |-> // [R1] [R5] [R8]
		pll_b_filter_order_sel_r == 3'h3 && osc_settle_wait_code_r == 2'h1
		&& !pll_b_narrow_bandwidth_r) else $error("Reset values wrong.");
	a_third_order: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R2]
		pll_b_third_order_o == (pll_b_filter_order_sel_o == 3'h7))
		else $error("Third-order flag wrong.");
	a_clsd_map: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R3]
		closed_loop_wait_code_r == 2'h1 |-> pll_b_closed_loop_cycles_o == 24'h003A98)
		else $error("Closed-loop wait count wrong.");
	a_osc_map: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R5]
		osc_settle_wait_code_r == 2'h3 |-> pll_b_osc_settle_cycles_o == 24'h989680)
		else $error("Oscillator wait count wrong.");
	a_bw_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R7]
		host_wr && reg_addr_i == PBC_OFF_BW_SELECT && !(state_r == PBC_ST_LOAD) |=>
		pll_b_jitter_cleaner_o == $past(reg_wdata_i[0]))
		else $error("Bandwidth bit not written.");
	a_count_inc: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R10]
		state_r == PBC_ST_IDLE && nv_prog_done_i && !nonvolatile_load_trigger_i
		&& nonvolatile_cycle_count_r != 8'hFF |=> nonvolatile_cycle_count_r ==
		$past(nonvolatile_cycle_count_r) + 8'h01 ##0 nv_count_we_o)
		else $error("Count did not increment.");
	a_count_sat: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R13]
		nonvolatile_cycle_count_r == 8'hFF && state_r != PBC_ST_LOAD |=>
		nonvolatile_cycle_count_r == 8'hFF) else $error("Count wrapped.");
	a_prog_reload: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R12]
		state_r == PBC_ST_PROG |=> state_r == PBC_ST_LOAD)
		else $error("No reload after program.");
	a_load_capture: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R12]
		state_r == PBC_ST_LOAD && nv_load_done_i |=>
		nonvolatile_cycle_count_r == $past(nv_cycle_count_i))
		else $error("Count not reloaded from store.");
	a_trig_load: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R14]
		state_r == PBC_ST_IDLE && nonvolatile_load_trigger_i |=> load_busy_o)
		else $error("Trigger ignored.");
	a_count_ro: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R15]
		state_r == PBC_ST_IDLE && !nv_prog_done_i |=> $stable(nonvolatile_cycle_count_r))
		else $error("Count changed by host.");
	c_prog: cover property (@(posedge clk_i) state_r == PBC_ST_PROG);
	c_trig: cover property (@(posedge clk_i) state_r == PBC_ST_IDLE && nonvolatile_load_trigger_i);
	c_sat: cover property (@(posedge clk_i) nonvolatile_cycle_count_r == 8'hFF && nv_prog_done_i);
	c_jitter: cover property (@(posedge clk_i) pll_b_jitter_cleaner_o && pll_b_third_order_o);
endmodule
`default_nettype wire

// File: include/pbc_pkg.sv
// Package for the second synthesizer settings and program-count register bank.
// Assumes an 8-bit register port driven by the serial host bus front end.
package pbc_pkg;
	// ***************************************************************
	// Register offsets and reset values
	// ***************************************************************
	localparam logic [7:0] PBC_OFF_FILTER_ORDER = 8'h84;
	localparam logic [7:0] PBC_OFF_SETTLE_WAITS = 8'h85;
	localparam logic [7:0] PBC_OFF_BW_SELECT = 8'h86;
	localparam logic [7:0] PBC_OFF_PROG_COUNT = 8'h88;
	localparam logic [2:0] PBC_FILTER_RST = 3'h3;
	localparam logic [2:0] PBC_FILTER_2ND = 3'h3;
	localparam logic [2:0] PBC_FILTER_3RD = 3'h7;
	localparam logic [1:0] PBC_CLSD_RST = 2'h0;
	localparam logic [1:0] PBC_OSC_RST = 2'h1;
	localparam logic PBC_NARROW_RST = 1'b0;
	localparam logic [7:0] PBC_COUNT_RST = 8'h00;
	localparam logic [7:0] PBC_COUNT_MAX = 8'hFF;
	// ***************************************************************
	// Field positions
	// ***************************************************************
	localparam int PBC_CLSD_LSB = 2;
	localparam int PBC_OSC_LSB = 0;
	// ***************************************************************
	// Settle times and cycle counts at 50 MHz
	// ***************************************************************
	localparam int PBC_CLK_HZ = 50000000;
	localparam longint PBC_CLSD_US0 = 30;
	localparam longint PBC_CLSD_US1 = 300;
	localparam longint PBC_CLSD_US2 = 30000;
	localparam longint PBC_CLSD_US3 = 300000;
	localparam longint PBC_OSC_US0 = 20;
	localparam longint PBC_OSC_US1 = 400;
	localparam longint PBC_OSC_US2 = 8000;
	localparam longint PBC_OSC_US3 = 200000;
	localparam longint PBC_CYC_PER_US = PBC_CLK_HZ / 1000000;
	localparam logic [23:0] PBC_CLSD_CYC0 = 24'(PBC_CLSD_US0 * PBC_CYC_PER_US);
	localparam logic [23:0] PBC_CLSD_CYC1 = 24'(PBC_CLSD_US1 * PBC_CYC_PER_US);
	localparam logic [23:0] PBC_CLSD_CYC2 = 24'(PBC_CLSD_US2 * PBC_CYC_PER_US);
	localparam logic [23:0] PBC_CLSD_CYC3 = 24'(PBC_CLSD_US3 * PBC_CYC_PER_US);
	localparam logic [23:0] PBC_OSC_CYC0 = 24'(PBC_OSC_US0 * PBC_CYC_PER_US);
	localparam logic [23:0] PBC_OSC_CYC1 = 24'(PBC_OSC_US1 * PBC_CYC_PER_US);
	localparam logic [23:0] PBC_OSC_CYC2 = 24'(PBC_OSC_US2 * PBC_CYC_PER_US);
	localparam logic [23:0] PBC_OSC_CYC3 = 24'(PBC_OSC_US3 * PBC_CYC_PER_US);
	typedef enum logic [2:0] {
		PBC_ST_LOAD = 3'b001,
		PBC_ST_IDLE = 3'b010,
		PBC_ST_PROG = 3'b100
	} pbc_state_e;
endpackage

// File: verification/pbc_store_model.sv
// Behavioural nonvolatile store seen from the register bank.
// Assumes the bank raises load_busy while it waits for a load and writes
// the program count back with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module pbc_store_model #(
	parameter int LOAD_DELAY = 4
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic load_busy_i,
	input wire logic prog_req_i,
	input wire logic count_we_i,
	input wire logic [7:0] count_wdata_i,
	output logic load_done_o,
	output logic prog_done_o,
	output logic [2:0] filter_o,
	output logic [1:0] closed_o,
	output logic [1:0] osc_o,
	output logic narrow_o,
	output logic [7:0] count_o
);
	logic [2:0] filter_r = 3'h3;
	logic [1:0] closed_r = 2'h0;
	logic [1:0] osc_r = 2'h1;
	logic narrow_r = 1'b0;
	logic [7:0] count_r = 8'h00;
	int wait_r;
	// Outside a load strobe the data lines show the inverse of the stored values.
	assign filter_o = load_done_o ? filter_r : ~filter_r;
	assign closed_o = load_done_o ? closed_r : ~closed_r;
	assign osc_o = load_done_o ? osc_r : ~osc_r;
	assign narrow_o = load_done_o ? narrow_r : ~narrow_r;
	assign count_o = load_done_o ? count_r : ~count_r;
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			load_done_o <= 1'b0;
			prog_done_o <= 1'b0;
			wait_r <= 0;
		end else begin
			prog_done_o <= prog_req_i;
			if (count_we_i)
				count_r <= count_wdata_i;
			if (load_done_o)
				load_done_o <= 1'b0;
			else if (load_busy_i && wait_r == LOAD_DELAY) begin
				load_done_o <= 1'b1;
				wait_r <= 0;
			end else if (load_busy_i)
				wait_r <= wait_r + 1;
		end
	end
endmodule
`default_nettype wire

// File: verification/pll_b_calibration_and_program_count_regs_bench.sv
// Self-checking bench for the second synthesizer register bank.
// Assumes the store model answers every load within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module pll_b_calibration_and_program_count_regs_bench;
	import pbc_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic wr = 1'b0, rd = 1'b0, trig = 1'b0, prog = 1'b0, busy, ld, pd, we, third, jit;
	logic [7:0] cnt_w, nv_cnt;
	logic [2:0] nv_f, fsel;
	logic [1:0] nv_c, nv_o;
	logic nv_n;
	logic [23:0] clsd_cyc, osc_cyc;
	int failures = 0, n_tests = 0;
	int clsd_us[4] = '{30, 300, 30000, 300000};
	int osc_us[4] = '{20, 400, 8000, 200000};
	pbc_regs u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .nonvolatile_load_trigger_i(trig),
		.load_busy_o(busy), .nv_load_done_i(ld), .nv_filter_order_i(nv_f),
		.nv_closed_loop_wait_i(nv_c), .nv_osc_settle_wait_i(nv_o), .nv_narrow_bandwidth_i(nv_n),
		.nv_cycle_count_i(nv_cnt), .nv_prog_done_i(pd), .nv_count_we_o(we),
		.nv_count_wdata_o(cnt_w), .pll_b_filter_order_sel_o(fsel), .pll_b_third_order_o(third),
		.pll_b_closed_loop_cycles_o(clsd_cyc), .pll_b_osc_settle_cycles_o(osc_cyc),
		.pll_b_jitter_cleaner_o(jit));
	pbc_store_model u_store (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_busy_i(busy),
		.prog_req_i(prog), .count_we_i(we), .count_wdata_i(cnt_w), .load_done_o(ld),
		.prog_done_o(pd), .filter_o(nv_f), .closed_o(nv_c), .osc_o(nv_o), .narrow_o(nv_n),
		.count_o(nv_cnt));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		#1;
		while (busy !== 1'b0 && n < 50) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk(24'(busy), 24'h000000);
	endtask
	// One-cycle strobe on the program-done request or the load trigger.
	task automatic strobe(input logic to_prog);
		@(posedge clk_i);
		if (to_prog) begin
			prog <= 1'b1;
		end else begin
			trig <= 1'b1;
		end
		@(posedge clk_i);
		prog <= 1'b0;
		trig <= 1'b0;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		wait_idle();
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		chk(24'(rdata), 24'(exp));
	endtask
	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_reset();
		wait_idle();
		rd_chk(PBC_OFF_FILTER_ORDER, 8'h03);
		rd_chk(PBC_OFF_SETTLE_WAITS, 8'h01);
		rd_chk(PBC_OFF_BW_SELECT, 8'h00);
		rd_chk(PBC_OFF_PROG_COUNT, 8'h00);
		rd_chk(8'h87, 8'h00);
		chk(24'(jit), 24'h000000);
		$display("t_reset done");
	endtask
	task automatic t_filter();
		wr_reg(PBC_OFF_FILTER_ORDER, 8'hFF);
		chk(24'(third), 24'h000001);
		rd_chk(PBC_OFF_FILTER_ORDER, 8'h07);
		wr_reg(PBC_OFF_FILTER_ORDER, 8'hF3);
		chk(24'(fsel), 24'h000003);
		chk(24'(third), 24'h000000);
		$display("t_filter done");
	endtask
	task automatic t_waits();
		for (int c = 0; c < 4; c++) begin
			wr_reg(PBC_OFF_SETTLE_WAITS, 8'hF0 | 8'(c * 5));
			chk(clsd_cyc, 24'(clsd_us[c] * 50));
			chk(osc_cyc, 24'(osc_us[c] * 50));
			rd_chk(PBC_OFF_SETTLE_WAITS, 8'(c * 5));
		end
		wr_reg(PBC_OFF_SETTLE_WAITS, 8'h05);
		$display("t_waits done");
	endtask
	task automatic t_bw();
		wr_reg(PBC_OFF_BW_SELECT, 8'hFF);
		wr_reg(PBC_OFF_FILTER_ORDER, 8'h07);
		chk(24'(jit), 24'h000001);
		rd_chk(PBC_OFF_BW_SELECT, 8'h01);
		wr_reg(PBC_OFF_BW_SELECT, 8'h00);
		wr_reg(PBC_OFF_FILTER_ORDER, 8'h03);
		chk(24'(jit), 24'h000000);
		$display("t_bw done");
	endtask
	task automatic prog_chk(input logic [7:0] exp);
		int n;
		strobe(1'b1);
		n = 0;
		#1;
		while (we !== 1'b1 && n < 8) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk(24'(we), 24'h000001);
		chk(24'(cnt_w), 24'(exp));
		wait_idle();
		rd_chk(PBC_OFF_PROG_COUNT, exp);
	endtask
	task automatic t_count();
		wr_reg(PBC_OFF_PROG_COUNT, 8'h5A);
		rd_chk(PBC_OFF_PROG_COUNT, 8'h00);
		prog_chk(8'h01);
		// The bank only sees a new stored count after a load.
		u_store.count_r = 8'hFE;
		strobe(1'b0);
		wait_idle();
		rd_chk(PBC_OFF_PROG_COUNT, 8'hFE);
		prog_chk(8'hFF);
		prog_chk(8'hFF);
		$display("t_count done");
	endtask
	task automatic t_trigger();
		u_store.filter_r = 3'h7;
		u_store.closed_r = 2'h2;
		u_store.narrow_r = 1'b1;
		strobe(1'b0);
		wait_idle();
		rd_chk(PBC_OFF_FILTER_ORDER, 8'h07);
		rd_chk(PBC_OFF_SETTLE_WAITS, 8'h09);
		chk(24'(jit), 24'h000001);
		$display("t_trigger done");
	endtask
	// Reset in mid-run: the store keeps its contents and reloads the bank.
	task automatic t_rereset();
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		#1;
		chk(24'(busy), 24'h000001);
		@(posedge clk_i);
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		wait_idle();
		rd_chk(PBC_OFF_PROG_COUNT, 8'hFF);
		rd_chk(PBC_OFF_FILTER_ORDER, 8'h07);
		chk(24'(jit), 24'h000001);
		$display("t_rereset done");
	endtask
	initial begin
		#(20 * 20000);
		failures++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_filter();
		t_waits();
		t_bw();
		t_count();
		t_trigger();
		t_rereset();
		stop_test();
	end
endmodule
`default_nettype wire
